// [common/dimmer_pkg.sv]
// Shared constants for the dimmer process image and its controller.
package dimmer_pkg;

	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned WORD_W    = 16;
	localparam int unsigned REGNO_W   = 6;
	localparam int unsigned REG_COUNT = 64;

	// Command and report byte fields.
	localparam int unsigned MODE_BIT = 7;
	localparam int unsigned RW_BIT   = 6;
	localparam int unsigned TRIG_BIT = 0;
	localparam int unsigned ERR_BIT  = 6;
	localparam int unsigned TEMP_BIT = 5;
	localparam int unsigned OVL_BIT  = 4;
	localparam int unsigned OPM_HI   = 3;
	localparam int unsigned OPM_LO   = 1;
	localparam int unsigned SYNC_BIT = 0;

	// Operating mode codes.
	localparam logic [2:0] OPM_DETECT   = 3'h0;
	localparam logic [2:0] OPM_TRAIL    = 3'h1;
	localparam logic [2:0] OPM_LEAD     = 3'h2;
	localparam logic [2:0] OPM_RECT_POS = 3'h3;
	localparam logic [2:0] OPM_RECT_NEG = 3'h4;

	// Thermal thresholds in whole degrees Celsius.
	localparam logic [15:0] TEMP_HIGH_C = 16'h0050;
	localparam logic [15:0] TEMP_LOW_C  = 16'h003C;

	// Output power range and the overtemperature limit in percent.
	localparam logic [15:0]  POWER_MAX   = 16'h7FFF;
	localparam int unsigned  CLAMP_PCT   = 20;
	localparam logic [15:0]  POWER_CLAMP =
		16'((32'(POWER_MAX) * CLAMP_PCT) / 32'd100);
	localparam logic [15:0]  WORD_RESET  = 16'h0000;
	localparam logic [7:0]   BYTE_RESET  = 8'h00;

	// Controller register map, byte addresses on AHB-Lite.
	localparam logic [7:0] ADDR_REQ      = 8'h00;
	localparam logic [7:0] ADDR_WDATA    = 8'h04;
	localparam logic [7:0] ADDR_POWER    = 8'h08;
	localparam logic [7:0] ADDR_DETECT   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_RDATA    = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

	localparam int unsigned REQ_GO_BIT     = 7;
	localparam int unsigned REQ_WR_BIT     = 6;
	localparam int unsigned STAT_BUSY_BIT  = 8;
	localparam int unsigned STAT_WORD_LO   = 16;

	localparam int unsigned IRQ_W    = 4;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_ERR  = 1;
	localparam int unsigned IRQ_TEMP = 2;
	localparam int unsigned IRQ_OVL  = 3;

	localparam int unsigned HTRANS_ACT_BIT = 1;
	localparam logic        HRESP_OKAY     = 1'b0;

endpackage

// [common/dimmer_image_if.sv]
// Process image exchanged between the controller and the dimmer terminal.
`timescale 1ns/1ps
`default_nettype none
interface dimmer_image_if;
	logic [dimmer_pkg::BYTE_W-1:0] host_command_byte;
	logic [dimmer_pkg::WORD_W-1:0] output_data_word;
	logic [dimmer_pkg::BYTE_W-1:0] terminal_report_byte;
	logic [dimmer_pkg::WORD_W-1:0] input_data_word;

	modport terminal (
		input  host_command_byte,
		input  output_data_word,
		output terminal_report_byte,
		output input_data_word
	);

	modport controller (
		output host_command_byte,
		output output_data_word,
		input  terminal_report_byte,
		input  input_data_word
	);
endinterface
`default_nettype wire

// [rtl/dimmer_terminal.sv]
// Dimmer terminal end: command/report byte handling and parameter registers.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Command byte in, report byte out.
// - Process mode: bit 7 clear, 6..1 zero.
// - Rising trigger bit starts load detection.
// - Process mode reported with bit 7 clear.
// - Short circuit sets error bit 6.
// - Above 80 C: warn, clamp power 20%.
// - Clamp releases itself below 60 C.
// - Overload sets report bit 4.
// - Operating mode code in bits 3..1.
// - Sync bit: synced and no short.
// - Bit 7 set enters register access.
// - Read returns register content in input word.
// - Write stores output word into register.
// - Register access acknowledged with bit 7 set.
// - Echo register number, bit 6 read/write.
// - Output word sets power, 0 to 32767.
// - Input word carries temperature in Celsius.

module dimmer_terminal (
	input  wire logic        i_clk_sys,       // System clock.
	input  wire logic        i_rst,           // Async reset, high.
	dimmer_image_if.terminal img,             // Process image.
	input  wire logic [15:0] i_temp_c,        // Temperature, degrees.
	input  wire logic        i_short_circuit, // Load short seen.
	input  wire logic        i_overload,      // Overload seen.
	input  wire logic        i_mains_synced,  // Locked to mains.
	input  wire logic        i_detect_busy,   // Load detection runs.
	input  wire logic [2:0]  i_load_mode,     // Set or found mode.
	output logic      [15:0] o_power,         // Output power value.
	output logic             o_detect_start,  // Start detection.
	output logic             o_clamp_active   // Thermal limit on.
);

	////////////////////////////////////////////////////////////////////////
	// Parameter register store.

	logic [dimmer_pkg::WORD_W-1:0] regfile [dimmer_pkg::REG_COUNT];

	////////////////////////////////////////////////////////////////////////
	// Command byte decode.

	wire logic [7:0]  cmd;
	wire logic        reg_path;
	wire logic        wr_req;
	wire logic [5:0]  regno;
	wire logic [15:0] out_word;

	assign cmd      = img.host_command_byte;
	assign out_word = img.output_data_word;
	assign reg_path = cmd[dimmer_pkg::MODE_BIT];
	assign wr_req   = cmd[dimmer_pkg::RW_BIT];
	assign regno    = cmd[dimmer_pkg::REGNO_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Load detection trigger.

	// The previous level is forced high outside process mode, so a
	// trigger bit carried over from a register number is never an edge.
	logic       trig_prev;
	wire  logic trig_rise;

	assign trig_rise = !reg_path
		&& cmd[dimmer_pkg::TRIG_BIT]
		&& !trig_prev;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			trig_prev <= 1'b1;
		end else begin
			trig_prev <= reg_path | cmd[dimmer_pkg::TRIG_BIT];
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_detect_start <= 1'b0;
		end else begin
			o_detect_start <= trig_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overtemperature warning with hysteresis.

	logic       hot;
	wire  logic next_hot;

	assign next_hot = (i_temp_c > dimmer_pkg::TEMP_HIGH_C) ? 1'b1 :
		(i_temp_c < dimmer_pkg::TEMP_LOW_C) ? 1'b0 : hot;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			hot            <= 1'b0;
			o_clamp_active <= 1'b0;
		end else begin
			hot            <= next_hot;
			o_clamp_active <= next_hot;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output power.

	// Values above the valid range are treated as full scale.
	wire logic [15:0] power_req;
	wire logic [15:0] next_power;

	assign power_req = (out_word > dimmer_pkg::POWER_MAX) ?
		dimmer_pkg::POWER_MAX : out_word;

	assign next_power = (next_hot
		&& power_req > dimmer_pkg::POWER_CLAMP) ?
		dimmer_pkg::POWER_CLAMP : power_req;

	// In register mode the output word carries register data, so the
	// last process value is held.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_power <= dimmer_pkg::WORD_RESET;
		end else if (!reg_path) begin
			o_power <= next_power;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Report byte assembly.

	wire logic [2:0] op_mode;
	wire logic       synced;
	logic      [7:0] proc_report;
	logic      [7:0] reg_report;
	wire logic [7:0] next_report;

	assign op_mode = i_detect_busy ?
		dimmer_pkg::OPM_DETECT : i_load_mode;

	assign synced = i_mains_synced && !i_short_circuit;

	always_comb begin
		proc_report = dimmer_pkg::BYTE_RESET;
		proc_report[dimmer_pkg::MODE_BIT] = 1'b0;
		proc_report[dimmer_pkg::ERR_BIT]  = i_short_circuit;
		proc_report[dimmer_pkg::TEMP_BIT] = next_hot;
		proc_report[dimmer_pkg::OVL_BIT]  = i_overload;
		proc_report[dimmer_pkg::OPM_HI:dimmer_pkg::OPM_LO] =
			op_mode;
		proc_report[dimmer_pkg::SYNC_BIT] = synced;
	end

	always_comb begin
		reg_report = dimmer_pkg::BYTE_RESET;
		reg_report[dimmer_pkg::MODE_BIT] = 1'b1;
		reg_report[dimmer_pkg::RW_BIT]   = wr_req;
		reg_report[dimmer_pkg::REGNO_W-1:0] = regno;
	end

	assign next_report = reg_path ? reg_report : proc_report;

	////////////////////////////////////////////////////////////////////////
	// Register access and input word.

	// A write is repeated each cycle the request stands; the stored
	// value is the same, so holding the request is harmless.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < dimmer_pkg::REG_COUNT; i++) begin
				regfile[i] <= dimmer_pkg::WORD_RESET;
			end
		end else if (reg_path && wr_req) begin
			regfile[regno] <= out_word;
		end
	end

	wire logic [15:0] next_in_word;

	assign next_in_word = reg_path ?
		regfile[regno] :
		i_temp_c;

	// Report and data are registered together, so the acknowledge and
	// the read data always appear in the same cycle.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			img.terminal_report_byte <= dimmer_pkg::BYTE_RESET;
			img.input_data_word      <= dimmer_pkg::WORD_RESET;
		end else begin
			img.terminal_report_byte <= next_report;
			img.input_data_word      <= next_in_word;
		end
	end

endmodule
`default_nettype wire

// [rtl/dimmer_controller.sv]
// Controller end: AHB-Lite registers driving the terminal process image.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dimmer_controller (
	input  wire logic          i_clk_sys,   // System clock.
	input  wire logic          i_rst,       // Async reset, high.
	input  wire logic          i_hsel,      // Slave select.
	input  wire logic [7:0]    i_haddr,     // Byte address.
	input  wire logic [1:0]    i_htrans,    // Transfer type.
	input  wire logic          i_hwrite,    // Write when high.
	input  wire logic [2:0]    i_hsize,     // Word only.
	input  wire logic [31:0]   i_hwdata,    // Write data.
	input  wire logic          i_hready,    // Bus ready.
	output logic      [31:0]   o_hrdata,    // Read data.
	output logic               o_hreadyout, // Slave ready.
	output logic               o_hresp,     // Always OKAY.
	output logic               o_irq,       // Interrupt level.
	dimmer_image_if.controller img          // Process image.
);

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_WAIT    = 3'b010,
		ST_RELEASE = 3'b100
	} ctrl_state_t;

	ctrl_state_t state;
	logic [5:0]  req_regno;
	logic        req_wr;
	logic [15:0] wdata;
	logic [15:0] power;
	logic        detect_trig;
	logic [15:0] rdata;
	logic [3:0]  irq_stat;
	logic [3:0]  irq_mask;
	logic [2:0]  flag_prev;
	logic        wr_pend;
	logic [7:0]  wr_addr;

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	wire logic [7:0] rep;
	wire logic       take;
	wire logic       rd_take;
	wire logic       wr_now;
	wire logic       go;
	wire logic       ack;
	wire logic [3:0] events;
	wire logic [3:0] next_stat;
	wire logic [31:0] status_word;
	wire logic [31:0] rd_mux;

	assign rep     = img.terminal_report_byte;
	assign take    = i_hsel && i_htrans[dimmer_pkg::HTRANS_ACT_BIT]
		&& i_hready;
	assign rd_take = take && !i_hwrite;
	assign wr_now  = wr_pend;
	assign go      = wr_now && wr_addr == dimmer_pkg::ADDR_REQ
		&& i_hwdata[dimmer_pkg::REQ_GO_BIT] && state == ST_IDLE;

	// Acknowledge counts only with the matching number and direction.
	assign ack = state == ST_WAIT && rep[dimmer_pkg::MODE_BIT]
		&& rep[dimmer_pkg::RW_BIT] == req_wr
		&& rep[dimmer_pkg::REGNO_W-1:0] == req_regno;

	assign events[dimmer_pkg::IRQ_DONE] = ack;
	assign events[dimmer_pkg::IRQ_ERR]  = !rep[dimmer_pkg::MODE_BIT]
		&& rep[dimmer_pkg::ERR_BIT] && !flag_prev[0];
	assign events[dimmer_pkg::IRQ_TEMP] = !rep[dimmer_pkg::MODE_BIT]
		&& rep[dimmer_pkg::TEMP_BIT] && !flag_prev[1];
	assign events[dimmer_pkg::IRQ_OVL]  = !rep[dimmer_pkg::MODE_BIT]
		&& rep[dimmer_pkg::OVL_BIT] && !flag_prev[2];

	// A new event wins over the clear by read in the same cycle.
	assign next_stat = (rd_take && i_haddr == dimmer_pkg::ADDR_IRQ_STAT) ?
		events : (irq_stat | events);

	assign status_word = {img.input_data_word, 7'h00,
		state != ST_IDLE, rep};

	assign rd_mux =
		(i_haddr == dimmer_pkg::ADDR_REQ) ?
			{24'h000000, 1'b0, req_wr, req_regno} :
		(i_haddr == dimmer_pkg::ADDR_WDATA)    ? {16'h0000, wdata} :
		(i_haddr == dimmer_pkg::ADDR_POWER)    ? {16'h0000, power} :
		(i_haddr == dimmer_pkg::ADDR_DETECT)   ? {31'h0, detect_trig} :
		(i_haddr == dimmer_pkg::ADDR_STATUS)   ? status_word :
		(i_haddr == dimmer_pkg::ADDR_RDATA)    ? {16'h0000, rdata} :
		(i_haddr == dimmer_pkg::ADDR_IRQ_STAT) ? {28'h0, irq_stat} :
		(i_haddr == dimmer_pkg::ADDR_IRQ_MASK) ? {28'h0, irq_mask} :
		32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// Bus slave and software registers.

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wr_pend     <= 1'b0;
			wr_addr     <= dimmer_pkg::BYTE_RESET;
			o_hrdata    <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp     <= dimmer_pkg::HRESP_OKAY;
		end else begin
			wr_pend <= take && i_hwrite;
			wr_addr <= i_haddr;
			if (rd_take) begin
				o_hrdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			req_regno   <= 6'h00;
			req_wr      <= 1'b0;
			wdata       <= dimmer_pkg::WORD_RESET;
			power       <= dimmer_pkg::WORD_RESET;
			detect_trig <= 1'b0;
			irq_mask    <= 4'h0;
		end else if (wr_now) begin
			if (go) begin
				req_regno <= i_hwdata[dimmer_pkg::REGNO_W-1:0];
				req_wr    <= i_hwdata[dimmer_pkg::REQ_WR_BIT];
			end else if (wr_addr == dimmer_pkg::ADDR_WDATA) begin
				wdata <= i_hwdata[15:0];
			end else if (wr_addr == dimmer_pkg::ADDR_POWER) begin
				power <= i_hwdata[15:0];
			end else if (wr_addr == dimmer_pkg::ADDR_DETECT) begin
				detect_trig <= i_hwdata[0];
			end else if (wr_addr == dimmer_pkg::ADDR_IRQ_MASK) begin
				irq_mask <= i_hwdata[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request sequencer and process image.

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state     <= ST_IDLE;
			rdata     <= dimmer_pkg::WORD_RESET;
			irq_stat  <= 4'h0;
			o_irq     <= 1'b0;
			flag_prev <= 3'h0;
		end else begin
			irq_stat  <= next_stat;
			o_irq     <= |(next_stat & irq_mask);
			// Register echoes reuse these bit positions, so the flags
			// are remembered only from process reports.
			if (!rep[dimmer_pkg::MODE_BIT]) begin
				flag_prev <= {rep[dimmer_pkg::OVL_BIT],
					rep[dimmer_pkg::TEMP_BIT],
					rep[dimmer_pkg::ERR_BIT]};
			end
			case (state)
				ST_IDLE: begin
					if (go) begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (ack) begin
						rdata <= img.input_data_word;
						state <= ST_RELEASE;
					end
				end
				ST_RELEASE: begin
					if (!rep[dimmer_pkg::MODE_BIT]) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			img.host_command_byte <= dimmer_pkg::BYTE_RESET;
			img.output_data_word  <= dimmer_pkg::WORD_RESET;
		end else if (state == ST_WAIT && !ack) begin
			img.host_command_byte <= {1'b1, req_wr, req_regno};
			img.output_data_word  <= req_wr ? wdata :
				dimmer_pkg::WORD_RESET;
		end else begin
			img.host_command_byte <= {7'h00, detect_trig};
			img.output_data_word  <= power;
		end
	end

endmodule
`default_nettype wire

// [dv/dimmer_image_properties.sv]
// Concurrent checks on the process image between controller and terminal.
`timescale 1ns/1ps
`default_nettype none
module dimmer_image_properties (
	input wire logic        i_clk_sys,            // System clock.
	input wire logic        i_rst,                // Async reset, high.
	input wire logic [7:0]  host_command_byte,    // Command byte.
	input wire logic [15:0] output_data_word,     // Output word.
	input wire logic [7:0]  terminal_report_byte, // Report byte.
	input wire logic [15:0] input_data_word       // Input word.
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	// High while the report byte acknowledges the pending request.
	wire logic match;
	assign match = host_command_byte[7] &&
		terminal_report_byte == {1'b1, host_command_byte[6:0]};

	////////////////////////////////////////////////////////////////////////
	reg_echo_a: assert property (
		$past(host_command_byte[7]) |-> terminal_report_byte ==
		{1'b1, $past(host_command_byte[6:0])})
		else $error("report byte does not echo the register request");
	proc_ack_a: assert property (
		!$past(host_command_byte[7]) |-> !terminal_report_byte[7])
		else $error("process mode not acknowledged");
	ack_bound_a: assert property (
		$rose(host_command_byte[7]) |-> ##[1:2] match)
		else $error("register request not acknowledged in time");
	req_hold_a: assert property (
		host_command_byte[7] && !match |=>
		$stable(host_command_byte) && $stable(output_data_word))
		else $error("request changed before acknowledge");
	req_release_a: assert property (
		match |=> !host_command_byte[7])
		else $error("request not released after acknowledge");
	reserved_zero_a: assert property (
		!host_command_byte[7] |-> host_command_byte[6:1] == 6'h00)
		else $error("reserved command bits not zero");
	sync_short_a: assert property (
		!terminal_report_byte[7] && terminal_report_byte[6] |->
		!terminal_report_byte[0])
		else $error("sync bit set during short circuit");
	opm_code_a: assert property (
		!terminal_report_byte[7] |-> terminal_report_byte[3:1] <= 3'h4)
		else $error("operating mode code out of range");

	////////////////////////////////////////////////////////////////////////
	cover property (match && host_command_byte[6]);
	cover property (match && !host_command_byte[6] && input_data_word != 0);
	cover property (!terminal_report_byte[7]
		&& $rose(terminal_report_byte[5]));
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the dimmer controller and terminal pair.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        i_clk_sys  = 1'b0;
	logic        i_rst      = 1'b1;
	logic        hsel       = 1'b0;
	logic [7:0]  haddr      = 8'h00;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h00000000;
	logic [15:0] temp       = 16'h0019;
	logic        shrt       = 1'b0;
	logic        ovl        = 1'b0;
	logic        syn        = 1'b0;
	logic        dbusy      = 1'b0;
	logic [2:0]  lmode      = 3'h1;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        irq;
	logic [15:0] power;
	logic        dstart;
	logic        clamp;
	logic [31:0] rd;
	int          fails      = 0;
	int          n_compared = 0;
	int          n_pulse    = 0;

	always #4 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) if (dstart === 1'b1) n_pulse++;

	dimmer_image_if img ();
	dimmer_terminal dimmer_terminal_inst (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .img(img), .i_temp_c(temp), .i_short_circuit(shrt),
		.i_overload(ovl), .i_mains_synced(syn), .i_detect_busy(dbusy),
		.i_load_mode(lmode), .o_power(power), .o_detect_start(dstart),
		.o_clamp_active(clamp));
	dimmer_controller dimmer_controller_inst (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .o_irq(irq), .img(img));
	dimmer_image_properties dimmer_image_properties_inst (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.host_command_byte(img.host_command_byte),
		.output_data_word(img.output_data_word),
		.terminal_report_byte(img.terminal_report_byte),
		.input_data_word(img.input_data_word));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge i_clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge i_clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask

	task automatic reg_req(input logic wr, input logic [5:0] n);
		logic busy;
		ahb(1'b1, dimmer_pkg::ADDR_REQ, {24'h000000, 1'b1, wr, n});
		busy = 1'b1;
		for (int i = 0; i < 20 && busy; i++) begin
			ahb(1'b0, dimmer_pkg::ADDR_STATUS, 32'h00000000);
			busy = rd[dimmer_pkg::STAT_BUSY_BIT] !== 1'b0;
		end
		chk({31'h00000000, busy}, 32'h00000000);
	endtask

	task automatic temp_chk(input logic [15:0] t, input logic [15:0] p,
		input logic c);
		@(posedge i_clk_sys);
		temp <= t;
		repeat (6) @(posedge i_clk_sys);
		chk({15'h0000, clamp, power}, {15'h0000, c, p});
		ahb(1'b0, dimmer_pkg::ADDR_STATUS, 32'h00000000);
		chk({31'h00000000, rd[5]}, {31'h00000000, c});
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		ahb(1'b1, dimmer_pkg::ADDR_WDATA, 32'h0000A5A5);
		reg_req(1'b1, 6'h00);
		ahb(1'b1, dimmer_pkg::ADDR_WDATA, 32'h00005A5A);
		reg_req(1'b1, 6'h3F);
		reg_req(1'b0, 6'h00);
		rd_chk(dimmer_pkg::ADDR_RDATA, 32'h0000A5A5);
		reg_req(1'b0, 6'h3F);
		rd_chk(dimmer_pkg::ADDR_RDATA, 32'h00005A5A);
		rd_chk(dimmer_pkg::ADDR_IRQ_STAT, 32'h00000001);
		rd_chk(dimmer_pkg::ADDR_IRQ_STAT, 32'h00000000);
	endtask

	task automatic t_proc;
		logic [2:0] lm;
		for (int m = 0; m < 6; m++) begin
			lm = (m == 5) ? 3'h2 : 3'(m);
			@(posedge i_clk_sys);
			lmode <= lm;
			shrt <= m[0];
			ovl <= m[1];
			syn <= 1'b1;
			dbusy <= (m == 5);
			temp <= 16'(20 + m);
			repeat (4) @(posedge i_clk_sys);
			ahb(1'b0, dimmer_pkg::ADDR_STATUS, 32'h00000000);
			chk(rd, {16'(20 + m), 9'h000, m[0], 1'b0, m[1],
				(m == 5) ? 3'h0 : lm, !m[0]});
		end
	endtask

	task automatic t_thermal;
		@(posedge i_clk_sys);
		shrt <= 1'b0;
		ovl <= 1'b0;
		dbusy <= 1'b0;
		ahb(1'b1, dimmer_pkg::ADDR_POWER, 32'h00007FFF);
		temp_chk(16'h0050, 16'h7FFF, 1'b0);
		temp_chk(16'h0051, dimmer_pkg::POWER_CLAMP, 1'b1);
		temp_chk(16'h003C, dimmer_pkg::POWER_CLAMP, 1'b1);
		temp_chk(16'h003B, 16'h7FFF, 1'b0);
		ahb(1'b1, dimmer_pkg::ADDR_POWER, 32'h0000FFFF);
		repeat (4) @(posedge i_clk_sys);
		chk({16'h0000, power}, 32'h00007FFF);
	endtask

	task automatic t_detect;
		int n0;
		n0 = n_pulse;
		ahb(1'b1, dimmer_pkg::ADDR_DETECT, 32'h00000001);
		ahb(1'b1, dimmer_pkg::ADDR_DETECT, 32'h00000001);
		ahb(1'b1, dimmer_pkg::ADDR_DETECT, 32'h00000000);
		ahb(1'b1, dimmer_pkg::ADDR_DETECT, 32'h00000001);
		repeat (4) @(posedge i_clk_sys);
		chk(32'(n_pulse - n0), 32'h00000002);
		ahb(1'b1, dimmer_pkg::ADDR_DETECT, 32'h00000000);
	endtask

	task automatic t_irq;
		ahb(1'b0, dimmer_pkg::ADDR_IRQ_STAT, 32'h00000000);
		ahb(1'b1, dimmer_pkg::ADDR_IRQ_MASK, 32'h00000000);
		@(posedge i_clk_sys);
		shrt <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		chk({31'h00000000, irq}, 32'h00000000);
		rd_chk(dimmer_pkg::ADDR_IRQ_STAT, 32'h00000002);
		@(posedge i_clk_sys);
		shrt <= 1'b0;
		ahb(1'b1, dimmer_pkg::ADDR_IRQ_MASK, 32'h00000002);
		rd_chk(dimmer_pkg::ADDR_IRQ_MASK, 32'h00000002);
		@(posedge i_clk_sys);
		shrt <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		chk({31'h00000000, irq}, 32'h00000001);
		rd_chk(dimmer_pkg::ADDR_IRQ_STAT, 32'h00000002);
		repeat (3) @(posedge i_clk_sys);
		chk({30'h00000000, irq, hresp}, 32'h00000000);
		rd_chk(8'h20, 32'h00000000);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		rd_chk(dimmer_pkg::ADDR_STATUS, 32'h00190002);
		t_regs();
		t_proc();
		t_thermal();
		t_detect();
		t_irq();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge i_clk_sys);
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire
